// File: sim/smct_ctrl_model.sv
/*
 * Controller model at the far side of the link: makes the module clock and
 * drives command, address, clock enable, byte masks and write data.
 * Assumes one bench process calls its tasks, one at a time.
 */
`timescale 1ns/1ps
module smct_ctrl_model (
   // Link clock and control
   output logic                     mem_clk,
   output logic                     cke,
   output smct_pkg::smct_cmd_pins_t cmd_pins,
   output logic [1:0]               ba,
   output logic [12:0]              addr,
   // Masks and write data
   output logic [7:0]               dqm,
   output logic [63:0]              dq_i
);
   logic held;

   // ---------------------------------------------------------------
   // Clock and released lines
   // ---------------------------------------------------------------
   // Start deselected with the clock enabled.
   initial
   begin
      mem_clk = 1'b0;
      cke = 1'b1;
      cmd_pins = 4'hf;
      ba = 2'h0;
      addr = 13'h0000;
      dqm = 8'h00;
      dq_i = 64'h0;
      held = 1'b0;
   end

   // The clock runs free at a constant rate.
   always #24 mem_clk = ~mem_clk;

   // Data lines that are let go show a pattern that changes each clock.
   always @(posedge mem_clk)
   begin
      if (!held)
      begin
         #1 dq_i <= ~dq_i;
      end
   end

   // ---------------------------------------------------------------
   // Command tasks
   // ---------------------------------------------------------------
   // Waits n edges and returns just after the last one.
   task automatic edges(input int n);
      repeat (n) @(posedge mem_clk);
      #2;
   endtask : edges

   // Drives one command and returns just after the edge that takes it.
   task automatic step(input logic [2:0] rcw, input logic [12:0] a, input logic [7:0] m,
                       input logic [63:0] d, input logic h);
      cmd_pins <= {1'b0, rcw};
      addr <= a;
      dqm <= m;
      dq_i <= d;
      held <= h;
      edges(1);
   endtask : step

   // Releases the command bus and the data lines.
   task automatic idle();
      cmd_pins <= 4'hf;
      dqm <= 8'h00;
      held <= 1'b0;
   endtask : idle

   task automatic set_cke(input logic v);
      cke <= v;
   endtask : set_cke

   // Selects the bank that later commands address.
   task automatic set_bank(input logic [1:0] b);
      ba <= b;
   endtask : set_bank

   // Power-up pause and two refreshes, each given its refresh period.
   task automatic power_up();
      #100000;
      edges(1);
      repeat (2)
      begin
         step(3'h1, 13'h0000, 8'h00, 64'h0, 1'b0);
         idle();
         edges(2);
      end
   endtask : power_up

   // Opens row r of the selected bank; one clock of 48 ns covers the access delay.
   task automatic act(input logic [1:0] r);
      step(3'h3, {11'h000, r}, 8'h00, 64'h0, 1'b0);
      idle();
      edges(1);
   endtask : act

   task automatic wr(input logic [3:0] c, input logic [7:0] m, input logic [63:0] d);
      step(3'h4, {9'h000, c}, m, d, 1'b1);
   endtask : wr

   // Later words of a write burst ride with no command.
   task automatic word(input logic [63:0] d);
      step(3'h7, 13'h0000, 8'h00, d, 1'b1);
   endtask : word

   // Recovery after the last write word before any other command.
   task automatic wr_end();
      idle();
      edges(5);
   endtask : wr_end

   task automatic rd(input logic [3:0] c, input logic [7:0] m);
      step(3'h5, {9'h000, c}, m, 64'h0, 1'b0);
   endtask : rd

   task automatic pre();
      step(3'h2, 13'h0000, 8'h00, 64'h0, 1'b0);
   endtask : pre

   // Mode load, then two clocks before anything else.
   task automatic mode(input logic [12:0] a);
      step(3'h0, a, 8'h00, 64'h0, 1'b0);
      idle();
      edges(2);
   endtask : mode

endmodule : smct_ctrl_model

// File: sim/tb_sdram_module_command_timing.sv
/*
 * Self-checking bench of the device end: each task drives the link through
 * the controller model and judges data pins and status outputs.
 * Assumes smct_pkg and smct_ctrl_model are compiled first.
 */
`timescale 1ns/1ps
module tb_sdram_module_command_timing;
   logic                     sys_clk = 1'b0;
   logic                     reset_n = 1'b0;
   logic                     clock_gated;
   logic                     write_seen;
   logic                     mem_clk;
   logic                     cke;
   smct_pkg::smct_cmd_pins_t cmd_pins;
   logic [1:0]               ba;
   logic [12:0]              addr;
   logic [7:0]               dqm;
   logic [63:0]              dq_i;
   logic [63:0]              dq_o;
   logic [7:0]               dq_oe;
   logic                     ws_hit = 1'b0;
   int                       miscompares = 0;
   int                       n_compared = 0;
   localparam logic [63:0]   PA = 64'h0123456789abcdef;
   localparam logic [63:0]   PB = 64'hfedcba9876543210;

   smct_ctrl_model u_ctrl (.mem_clk(mem_clk), .cke(cke), .cmd_pins(cmd_pins), .ba(ba),
                           .addr(addr), .dqm(dqm), .dq_i(dq_i));
   smct_device u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clock_gated(clock_gated),
                      .write_seen(write_seen), .mem_clk(mem_clk), .cke(cke),
                      .cmd_pins(cmd_pins), .ba(ba), .addr(addr), .dqm(dqm), .dq_i(dq_i),
                      .dq_o(dq_o), .dq_oe(dq_oe));

   // ---------------------------------------------------------------
   // Clock, activity monitor and compare tasks
   // ---------------------------------------------------------------
   // System clock of 100 ns.
   always #50 sys_clk = ~sys_clk;

   // Notes any stored-write pulse on the system side.
   always @(posedge sys_clk)
   begin
      if (write_seen === 1'b1)
      begin
         ws_hit <= 1'b1;
      end
   end

   task automatic cmp_data(input string w, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask : cmp_data

   task automatic cmp_lanes(input string w, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask : cmp_lanes

   task automatic cmp_flag(input string w, input logic e, input logic g);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask : cmp_flag

   // Reads one column at latency three and checks word, lanes and release.
   task automatic rd_one(input logic [3:0] c, input logic [63:0] e);
      u_ctrl.rd(c, 8'h00);
      u_ctrl.idle();
      u_ctrl.edges(2);
      cmp_data("read word", e, dq_o);
      cmp_lanes("read lanes", 8'hff, dq_oe);
      u_ctrl.edges(1);
      cmp_lanes("read release", 8'h00, dq_oe);
   endtask : rd_one

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Back-to-back writes, two to column 0 with the second masking lane 0, then one to column 1.
   task automatic t_write_mask();
      u_ctrl.act(2'h0);
      u_ctrl.wr(4'h0, 8'h00, PA);
      u_ctrl.wr(4'h0, 8'h01, PB);
      u_ctrl.wr(4'h1, 8'h00, PB);
      u_ctrl.wr_end();
      rd_one(4'h0, {PB[63:8], PA[7:0]});
      rd_one(4'h1, PB);
   endtask : t_write_mask

   // Back-to-back reads, the second masking the low four lanes.
   task automatic t_read_mask();
      u_ctrl.rd(4'h0, 8'h00);
      u_ctrl.rd(4'h1, 8'h0f);
      u_ctrl.idle();
      u_ctrl.edges(1);
      cmp_data("first read word", {PB[63:8], PA[7:0]}, dq_o);
      u_ctrl.edges(1);
      cmp_lanes("masked read lanes", 8'hf0, dq_oe);
      cmp_data("unmasked lanes", PB & 64'hffffffff00000000,
               dq_o & 64'hffffffff00000000);
   endtask : t_read_mask

   // Eight-word bursts; precharge one clock into the read cuts it off.
   task automatic t_prech_float();
      for (int cl = 2; cl <= 3; cl++)
      begin
         u_ctrl.mode({6'h00, 1'b0, cl[1:0], 4'h3});
         u_ctrl.act(2'h0);
         u_ctrl.wr(4'h0, 8'h00, {8{8'h10}});
         for (int i = 1; i < 8; i++)
         begin
            u_ctrl.word({8{8'h10 + i[7:0]}});
         end
         u_ctrl.wr_end();
         u_ctrl.rd(4'h0, 8'h00);
         u_ctrl.pre();
         u_ctrl.idle();
         u_ctrl.edges(cl - 2);
         cmp_data("burst word", {8{8'h10}}, dq_o);
         cmp_lanes("burst lanes", 8'hff, dq_oe);
         u_ctrl.edges(1);
         cmp_lanes("precharge release", 8'h00, dq_oe);
         u_ctrl.edges(5);
      end
      u_ctrl.mode(13'h0030);
   endtask : t_prech_float

   // Clock enable drop and return, each acting one clock later.
   task automatic t_clock_gate();
      u_ctrl.act(2'h0);
      for (int c = 5; c <= 8; c++)
      begin
         u_ctrl.wr(c[3:0], 8'h00, PA);
      end
      u_ctrl.wr_end();
      u_ctrl.set_cke(1'b0);
      u_ctrl.wr(4'h5, 8'h00, PB);
      u_ctrl.wr(4'h6, 8'h00, PB);
      u_ctrl.idle();
      u_ctrl.edges(8);
      cmp_flag("clock gated", 1'b1, clock_gated);
      u_ctrl.set_cke(1'b1);
      u_ctrl.wr(4'h7, 8'h00, PB);
      u_ctrl.wr(4'h8, 8'h00, PB);
      u_ctrl.wr_end();
      u_ctrl.edges(8);
      cmp_flag("clock running", 1'b0, clock_gated);
      rd_one(4'h5, PB);
      rd_one(4'h6, PA);
      rd_one(4'h7, PA);
      rd_one(4'h8, PB);
      cmp_flag("write activity", 1'b1, ws_hit);
   endtask : t_clock_gate

   // Another bank and row keep their own words apart from bank 0, row 0.
   task automatic t_bank_row();
      u_ctrl.set_bank(2'h2);
      u_ctrl.act(2'h3);
      u_ctrl.wr(4'h2, 8'h00, PB);
      u_ctrl.wr_end();
      rd_one(4'h2, PB);
      u_ctrl.set_bank(2'h0);
      u_ctrl.act(2'h0);
      rd_one(4'h2, {8{8'h12}});
   endtask : t_bank_row

   task automatic results();
      if (miscompares == 0 && n_compared > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // Reset, power-up sequence, then every scenario in turn.
   initial
   begin
      repeat (6) @(posedge sys_clk);
      #2 reset_n = 1'b1;
      u_ctrl.power_up();
      t_write_mask();
      t_read_mask();
      t_prech_float();
      t_clock_gate();
      t_bank_row();
      results();
   end

   // Cuts a hang short well past the expected run of about 110 us.
   initial
   begin
      #2000000;
      miscompares++;
      results();
   end

endmodule : tb_sdram_module_command_timing

// File: src/smct_device.sv
/*
 * Device end of the SDRAM module command-timing model: command decode,
 * burst engine, byte masking, read latency pipe, clock-enable gating and
 * a small storage array, plus status crossing into the system clock.
 * Assumes the controller keeps the timing rules that bind it and drives
 * all link pins synchronously to mem_clk.
 */
`timescale 1ns/1ps
module smct_device #(
   parameter int DW    = 64,
   parameter int ROW_W = 2,
   parameter int COL_W = 4
) (
   // System side
   input  wire logic                   sys_clk,
   input  wire logic                   reset_n,
   output logic                        clock_gated,
   output logic                        write_seen,
   // Link side
   input  wire logic                   mem_clk,
   input  wire logic                   cke,
   input  smct_pkg::smct_cmd_pins_t    cmd_pins,
   input  wire logic [1:0]             ba,
   input  wire logic [12:0]            addr,
   input  wire logic [DW/8-1:0]        dqm,
   // Data pins
   input  wire logic [DW-1:0]          dq_i,
   output logic      [DW-1:0]          dq_o,
   output logic      [DW/8-1:0]        dq_oe
);

   localparam int LANES = DW / 8;
   localparam int IDX_W = 2 + ROW_W + COL_W;

   // ------------------------------------------------------------------
   // Link reset and decode
   // ------------------------------------------------------------------
   logic [1:0]          mem_rst_q;
   logic                mem_rst_n;
   logic                clk_en_q;
   smct_pkg::smct_cmd_t cmd_w;
   logic [2:0]          bl_q;
   logic [1:0]          rl_q;
   logic [ROW_W-1:0]    open_row_q [4];
   logic [1:0]          bank_q;
   logic [COL_W-1:0]    col_q;
   logic [COL_W-1:0]    left_q;
   logic                burst_rd_q;
   logic                burst_wr_q;
   logic                start_rd;
   logic                start_wr;
   logic                stop_burst;
   logic                wr_en;
   logic                rd_issue;
   logic [1:0]          cur_bank;
   logic [COL_W-1:0]    cur_col;
   logic [IDX_W-1:0]    cur_idx;
   logic [LANES-1:0]    wr_lanes;
   logic [DW-1:0]       rd_word;
   smct_pkg::smct_rd_slot_t rd_pipe_q [1:2];
   logic [LANES-1:0]    dqm_p1_q;
   logic [LANES-1:0]    dqm_p2_q;
   logic                wr_tog_q;

   // Reset is released into the link domain through two flops.
   always_ff @(posedge mem_clk or negedge reset_n)
   begin
      if (!reset_n)
         mem_rst_q <= 2'h0;
      else
         mem_rst_q <= {mem_rst_q[0], 1'b1};
   end
   assign mem_rst_n = mem_rst_q[1];

   // Clock enable is registered, so gating takes effect one clock later.
   always_ff @(posedge mem_clk or negedge reset_n)
   begin
      if (!reset_n)
         clk_en_q <= 1'b1;
      else
         clk_en_q <= cke;
   end

   // Command decode and burst control terms of the current clock.
   always_comb
   begin
      cmd_w      = smct_pkg::smct_decode(cmd_pins);
      start_rd   = clk_en_q && (cmd_w == smct_pkg::CMD_RD);
      start_wr   = clk_en_q && (cmd_w == smct_pkg::CMD_WR);
      stop_burst = clk_en_q && (cmd_w == smct_pkg::CMD_BST || cmd_w == smct_pkg::CMD_PRE);
      cur_bank   = (start_rd || start_wr) ? ba : bank_q;
      cur_col    = (start_rd || start_wr) ? addr[COL_W-1:0] : col_q;
      cur_idx    = {cur_bank, open_row_q[cur_bank], cur_col};
      // A write word is stored with its command, and every later burst word.
      wr_en      = start_wr ||
                   (clk_en_q && burst_wr_q && !stop_burst && !start_rd);
      rd_issue   = start_rd ||
                   (clk_en_q && burst_rd_q && !stop_burst && !start_wr);
      wr_lanes   = wr_en ? ~dqm : '0;
   end

   // Burst words left after the first, from the mode register code.
   function automatic logic [COL_W-1:0] burst_left(input logic [2:0] code);
      logic [COL_W-1:0] n;
      n = '0;
      case (code)
         3'h0:                 n = COL_W'(0);
         3'h1:                 n = COL_W'(1);
         3'h2:                 n = COL_W'(3);
         3'h3:                 n = COL_W'(7);
         smct_pkg::BL_CODE_FULL: n = '1;
         default:              n = COL_W'(0);
      endcase
      return n;
   endfunction : burst_left

   // ------------------------------------------------------------------
   // Mode register and open rows
   // ------------------------------------------------------------------
   always_ff @(posedge mem_clk or negedge mem_rst_n)
   begin
      if (!mem_rst_n)
      begin
         bl_q <= smct_pkg::MODE_BL_RESET;
         rl_q <= smct_pkg::READ_LATENCY_RST;
      end
      else if (clk_en_q && cmd_w == smct_pkg::CMD_MRS)
      begin
         bl_q <= addr[smct_pkg::MODE_BL_LSB +: 3];
         // Only latencies two and three are honoured; others keep the old one.
         if (addr[smct_pkg::MODE_CL_LSB +: 3] == {1'b0, smct_pkg::READ_LATENCY_2} ||
             addr[smct_pkg::MODE_CL_LSB +: 3] == {1'b0, smct_pkg::READ_LATENCY_3})
            rl_q <= addr[smct_pkg::MODE_CL_LSB +: 2];
      end
   end

   // Row latch per bank on activate.
   always_ff @(posedge mem_clk or negedge mem_rst_n)
   begin
      if (!mem_rst_n)
      begin
         for (int b = 0; b < 4; b++)
            open_row_q[b] <= '0;
      end
      else if (clk_en_q && cmd_w == smct_pkg::CMD_ACT)
      begin
         open_row_q[ba] <= addr[ROW_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // Burst engine
   // ------------------------------------------------------------------
   // A new column command cuts the running burst; stop or precharge ends it.
   always_ff @(posedge mem_clk or negedge mem_rst_n)
   begin
      if (!mem_rst_n)
      begin
         bank_q     <= 2'h0;
         col_q      <= '0;
         left_q     <= '0;
         burst_rd_q <= 1'b0;
         burst_wr_q <= 1'b0;
      end
      else if (start_rd || start_wr)
      begin
         bank_q     <= ba;
         col_q      <= addr[COL_W-1:0] + COL_W'(1);
         left_q     <= burst_left(bl_q);
         burst_rd_q <= start_rd && (burst_left(bl_q) != '0);
         burst_wr_q <= start_wr && (burst_left(bl_q) != '0);
      end
      else if (stop_burst)
      begin
         burst_rd_q <= 1'b0;
         burst_wr_q <= 1'b0;
      end
      else if (clk_en_q && (burst_rd_q || burst_wr_q))
      begin
         col_q  <= col_q + COL_W'(1);
         left_q <= left_q - COL_W'(1);
         if (left_q == COL_W'(1))
         begin
            burst_rd_q <= 1'b0;
            burst_wr_q <= 1'b0;
         end
      end
   end

   // Storage with per-lane write strobes; each lane owns its array, so no
   // word is written from more than one process.
   for (genvar g = 0; g < LANES; g++)
   begin : g_lane
      logic [7:0] lane_q [2**IDX_W];

      always_ff @(posedge mem_clk)
      begin
         if (wr_lanes[g])
            lane_q[cur_idx] <= dq_i[8*g +: 8];
      end

      // The lane's byte at the current column feeds the read pipe.
      assign rd_word[8*g +: 8] = lane_q[cur_idx];
   end

   // ------------------------------------------------------------------
   // Read pipe and output drivers
   // ------------------------------------------------------------------
   // The pipe and mask delay only advance on enabled clocks.
   always_ff @(posedge mem_clk or negedge mem_rst_n)
   begin
      if (!mem_rst_n)
      begin
         rd_pipe_q[1] <= '0;
         rd_pipe_q[2] <= '0;
         dqm_p1_q     <= '0;
         dqm_p2_q     <= '0;
      end
      else if (clk_en_q)
      begin
         // A precharge leaves an empty slot, floating the bus a latency later.
         rd_pipe_q[1] <= '{valid: rd_issue, data: 64'(rd_word)};
         rd_pipe_q[2] <= rd_pipe_q[1];
         dqm_p1_q     <= dqm;
         dqm_p2_q     <= dqm_p1_q;
      end
   end

   // Output register picks the pipe stage that matches the read latency.
   always_ff @(posedge mem_clk or negedge mem_rst_n)
   begin
      if (!mem_rst_n)
      begin
         dq_o  <= '0;
         dq_oe <= '0;
      end
      else if (clk_en_q)
      begin
         if (rl_q == smct_pkg::READ_LATENCY_2)
         begin
            dq_o  <= DW'(rd_pipe_q[1].data);
            dq_oe <= {LANES{rd_pipe_q[1].valid}} & ~dqm_p2_q;
         end
         else
         begin
            dq_o  <= DW'(rd_pipe_q[2].data);
            dq_oe <= {LANES{rd_pipe_q[2].valid}} & ~dqm_p2_q;
         end
      end
   end

   // Toggle marks each stored word for the system side.
   always_ff @(posedge mem_clk or negedge mem_rst_n)
   begin
      if (!mem_rst_n)
         wr_tog_q <= 1'b0;
      else if (wr_en)
         wr_tog_q <= ~wr_tog_q;
   end

   // ------------------------------------------------------------------
   // System clock crossing
   // ------------------------------------------------------------------
   logic [1:0] gate_sync_q;
   logic [2:0] tog_sync_q;
   logic       write_seen_q;

   // Gating level through two flops, write toggle through two plus edge flop.
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gate_sync_q  <= 2'h0;
         tog_sync_q   <= 3'h0;
         write_seen_q <= 1'b0;
      end
      else
      begin
         gate_sync_q  <= {gate_sync_q[0], ~clk_en_q};
         tog_sync_q   <= {tog_sync_q[1:0], wr_tog_q};
         write_seen_q <= tog_sync_q[2] ^ tog_sync_q[1];
      end
   end
   assign clock_gated = gate_sync_q[1];
   assign write_seen  = write_seen_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mem_clk); endclocking
   default disable iff (!mem_rst_n);

   chk_gate_entry_hold: assert property (!cke |=> !wr_en && !rd_issue && $stable(left_q))
      else $error("Work done in a clock after enable was sampled low.");
   chk_gate_exit_run: assert property (cke ##1 (cmd_w == smct_pkg::CMD_WR) |-> wr_en)
      else $error("Write not taken one clock after enable returned high.");
   chk_column_back_to_back: assert property ((start_rd ##1 start_rd) |=> rd_pipe_q[1].valid)
      else $error("Back-to-back read not issued.");
   chk_write_first_word: assert property (start_wr |-> wr_en && cur_col == addr[COL_W-1:0]
                                          && cur_bank == ba)
      else $error("First write word not stored with its command.");
   chk_write_mask_now: assert property (wr_en |-> wr_lanes == ~dqm)
      else $error("Write strobes differ from the mask of the same cycle.");
   chk_masked_lanes_kept: assert property ((wr_en && dqm == '1) |-> wr_lanes == '0)
      else $error("Fully masked write still stored a lane.");
   chk_read_mask_float: assert property ((dqm[0] && clk_en_q) ##1 clk_en_q ##1 clk_en_q
                                         |=> !dq_oe[0])
      else $error("Masked lane still driven two clocks later.");
   chk_pre_float_cl3: assert property ((clk_en_q && cmd_w == smct_pkg::CMD_PRE &&
                                        rl_q == smct_pkg::READ_LATENCY_3)
                                       ##1 clk_en_q ##1 clk_en_q |=> dq_oe == '0)
      else $error("Outputs driven after precharge at latency three.");
   chk_pre_float_cl2: assert property ((clk_en_q && cmd_w == smct_pkg::CMD_PRE &&
                                        rl_q == smct_pkg::READ_LATENCY_2)
                                       ##1 clk_en_q |=> dq_oe == '0)
      else $error("Outputs driven after precharge at latency two.");

   cov_write_burst: cover property (start_wr ##1 wr_en ##1 wr_en);
   cov_read_precharged: cover property (start_rd ##1 (clk_en_q && cmd_w == smct_pkg::CMD_PRE));
   cov_suspend_in_burst: cover property (burst_rd_q && !clk_en_q ##1 clk_en_q);

endmodule : smct_device

// File: src/smct_pkg.sv
/*
 * Shared constants, command codes and carrier types of the SDRAM module
 * command-timing model (device end).
 * Assumes a memory controller drives the command pins synchronously to
 * the module clock, and a system clock domain reads the block's status.
 */
// Function
// - Column commands may follow each other on every consecutive clock.
// - Clock enable sampled low suspends the device one clock later.
// - Clock enable returning high resumes the device one clock later.
// - Byte mask acts on write data in the same cycle it is sampled.
// - Masked byte lanes of a write burst are not stored.
// - Byte mask during reads floats that lane's outputs two clocks later.
// - First write word is captured with the write command itself.
// - Precharge during a read floats outputs after read latency clocks.
package smct_pkg;

   // ------------------------------------------------------------------
   // Mode register fields and reset values
   // ------------------------------------------------------------------
   localparam int         MODE_BL_LSB     = 0;
   localparam int         MODE_CL_LSB     = 4;
   localparam logic [2:0] MODE_BL_RESET   = 3'h0;
   localparam logic [1:0] READ_LATENCY_RST = 2'h3;
   localparam logic [1:0] READ_LATENCY_2  = 2'h2;
   localparam logic [1:0] READ_LATENCY_3  = 2'h3;
   localparam logic [2:0] BL_CODE_FULL    = 3'h7;

   // ------------------------------------------------------------------
   // Timing counts in module clocks
   // ------------------------------------------------------------------
   localparam int CLOCK_GATE_ENTRY_LATENCY = 1;
   localparam int CLOCK_GATE_EXIT_LATENCY  = 1;
   localparam int MASK_TO_WRITE_MASK_DELAY = 0;
   localparam int MASK_TO_READ_FLOAT_DELAY = 2;
   localparam int WRITE_TO_INPUT_DELAY     = 0;
   localparam int COLUMN_COMMAND_GAP       = 1;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_MRS
   } smct_cmd_t;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } smct_cmd_pins_t;

   typedef struct packed {
      logic        valid;
      logic [63:0] data;
   } smct_rd_slot_t;

   // Turns the four command strobes into a command.
   function automatic smct_cmd_t smct_decode(input smct_cmd_pins_t p);
      smct_cmd_t c;
      c = CMD_NOP;
      if (p.cs_n)
      begin
         c = CMD_DESEL;
      end
      else
      begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h3:    c = CMD_ACT;
            3'h5:    c = CMD_RD;
            3'h4:    c = CMD_WR;
            3'h6:    c = CMD_BST;
            3'h2:    c = CMD_PRE;
            3'h1:    c = CMD_REF;
            3'h0:    c = CMD_MRS;
            default: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction : smct_decode

endpackage : smct_pkg
